// ---- logic/edge_interval_count_timer.sv ----
// Purpose: edge interval / edge count within a window measurement sub-block.
// Assumes: all inputs synchronous to clk; registers are held outside as levels.
// Notes:   register fields arrive as plain levels; a completed measurement re-arms itself.
`timescale 1ns/1ns
module edge_interval_count_timer
  import edge_timer_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic [7:0]     unit_enable_reg,
  input  wire logic [15:0]    prescaler_ratio_reg,
  input  wire subblock_ctrl_s subblock_control,
  input  wire logic [31:0]    subblock_start_reg,
  input  wire logic [31:0]    time_general_reg,
  input  wire logic [15:0]    edge_number_reg,
  input  wire logic [7:0]     irq_enable_reg,
  input  wire logic           flag_clear_wr,
  input  wire logic [7:0]     flag_clear_reg,
  input  wire logic           edge_preset_wr,
  input  wire logic [15:0]    edge_preset_data,
  input  wire logic           measure_input_pin,
  output logic [31:0]         capture_data_reg,
  output logic                capture_flag,
  output logic                capture_irq,
  output logic [31:0]         time_measure_counter,
  output logic [15:0]         edge_counter,
  output logic                busy
);
  // ------------------------------------------------------------
  // clock bus and edge detect
  // ------------------------------------------------------------
  logic bus0_tick;
  logic bus_tick;
  logic pin_prev_r;
  logic edge_hit;
  logic go;

  clock_bus_prescaler u_psc (
    .clk      (clk),
    .rstn     (rstn),
    .enable   (unit_enable_reg[UEN_PRESCALER_BIT]),
    .ratio_m1 (prescaler_ratio_reg),
    .tick     (bus0_tick)
  );

  // unknown bus selections never tick rather than guessing a source
  assign bus_tick = bus0_tick && (subblock_control.bus_sel == CLK_BUS0);

  // pin assumed glitch-free and synchronous; no filter here
  always_comb
  begin
    case (subblock_control.edge_sel)
      EDGE_RISE: edge_hit = measure_input_pin && !pin_prev_r;
      EDGE_FALL: edge_hit = !measure_input_pin && pin_prev_r;
      EDGE_BOTH: edge_hit = measure_input_pin != pin_prev_r;
      default:   edge_hit = 1'b0;
    endcase
  end

  assign go = unit_enable_reg[UEN_TIMER_BIT] && subblock_start_reg[START_SB0_BIT];

  // ------------------------------------------------------------
  // measurement state
  // ------------------------------------------------------------
  meas_state_e state_r;
  meas_state_e state_nxt;
  logic [31:0] time_nxt;
  logic [15:0] edge_nxt;
  logic [31:0] cap_nxt;
  logic        done;
  logic        flag_nxt;
  logic        irq_nxt;
  logic        busy_nxt;

  always_comb
  begin
    state_nxt = state_r;
    time_nxt  = time_measure_counter;
    edge_nxt  = edge_counter;
    cap_nxt   = capture_data_reg;
    done      = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (go)
        begin
          state_nxt = ST_RUN;
          time_nxt  = TIME_CNT_RST;
        end
      end
      ST_RUN:
      begin
        if (!go)
          state_nxt = ST_IDLE;
        else
        begin
          if (bus_tick)
            time_nxt = time_measure_counter + 32'h0000_0001;
          if (edge_hit)
            edge_nxt = edge_counter + 16'h0001;
          if (subblock_control.mode == MODE_EDGE_INTERVAL)
          begin
            if (edge_hit && edge_nxt == edge_number_reg)
            begin
              cap_nxt  = time_nxt;
              done     = 1'b1;
              time_nxt = TIME_CNT_RST;
              edge_nxt = EDGE_CNT_RST;
            end
          end
          else if (subblock_control.mode == MODE_EDGE_WINDOW)
          begin
            if (bus_tick && time_nxt == time_general_reg)
            begin
              cap_nxt  = {CAP_PAD, edge_nxt};
              done     = 1'b1;
              time_nxt = TIME_CNT_RST;
              edge_nxt = EDGE_CNT_RST;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // software preset of the edge counter overrides counting in that cycle
    if (edge_preset_wr)
      edge_nxt = edge_preset_data;
    // a completion in the clear cycle wins, so no event is lost
    flag_nxt = done || (capture_flag && !(flag_clear_wr && flag_clear_reg[FCLR_SB0_BIT]));
    irq_nxt  = flag_nxt && irq_enable_reg[IER_SB0_BIT];
    busy_nxt = (state_nxt == ST_RUN);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r              <= ST_IDLE;
      pin_prev_r           <= 1'b0;
      time_measure_counter <= TIME_CNT_RST;
      edge_counter         <= EDGE_CNT_RST;
      capture_data_reg     <= CAPTURE_RST;
      capture_flag         <= 1'b0;
      capture_irq          <= 1'b0;
      busy                 <= 1'b0;
    end
    else
    begin
      state_r              <= state_nxt;
      pin_prev_r           <= measure_input_pin;
      time_measure_counter <= time_nxt;
      edge_counter         <= edge_nxt;
      capture_data_reg     <= cap_nxt;
      capture_flag         <= flag_nxt;
      capture_irq          <= irq_nxt;
      busy                 <= busy_nxt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic run_ok;
  logic is_int;
  logic is_win;
  assign run_ok = (state_r == ST_RUN) && go && !edge_preset_wr;
  assign is_int = subblock_control.mode == MODE_EDGE_INTERVAL;
  assign is_win = subblock_control.mode == MODE_EDGE_WINDOW;

  sequence s_int_last;
    run_ok && is_int && edge_hit && (edge_counter + 16'h0001 == edge_number_reg);
  endsequence

  sequence s_win_end;
    run_ok && is_win && bus_tick && (time_measure_counter + 32'h0000_0001 == time_general_reg);
  endsequence

  sequence s_psc_quiet;
    (!bus0_tick && unit_enable_reg[UEN_PRESCALER_BIT] && prescaler_ratio_reg == 16'h0009)[*8];
  endsequence

  property p_int_done;
    @(posedge clk) disable iff (!rstn)
    s_int_last |=> capture_flag && edge_counter == EDGE_CNT_RST && time_measure_counter == 32'h0000_0000;
  endproperty
  a_int_done: assert property (p_int_done) else $error("interval end missed");

  // the tick of the completing cycle still belongs to the elapsed time
  property p_int_capture;
    @(posedge clk) disable iff (!rstn)
    s_int_last |=> capture_data_reg
      == $past(time_measure_counter) + ($past(bus_tick) ? 32'h0000_0001 : 32'h0000_0000);
  endproperty
  a_int_capture: assert property (p_int_capture) else $error("interval capture wrong");

  property p_edge_step;
    @(posedge clk) disable iff (!rstn)
    (run_ok && is_int && edge_hit && edge_counter + 16'h0001 != edge_number_reg)
      |=> edge_counter == $past(edge_counter) + 16'h0001 && !$rose(capture_flag);
  endproperty
  a_edge_step: assert property (p_edge_step) else $error("edge count step wrong");

  property p_win_done;
    @(posedge clk) disable iff (!rstn)
    s_win_end |=> capture_flag && time_measure_counter == 32'h0000_0000;
  endproperty
  a_win_done: assert property (p_win_done) else $error("window end missed");

  property p_win_capture;
    @(posedge clk) disable iff (!rstn)
    (s_win_end and !edge_hit) |=> capture_data_reg == {CAP_PAD, $past(edge_counter)};
  endproperty
  a_win_capture: assert property (p_win_capture) else $error("window capture wrong");

  property p_time_tick;
    @(posedge clk) disable iff (!rstn)
    (run_ok && is_int && bus_tick && !edge_hit)
      |=> time_measure_counter == $past(time_measure_counter) + 32'h0000_0001;
  endproperty
  a_time_tick: assert property (p_time_tick) else $error("time counter missed tick");

  property p_flag_clear;
    @(posedge clk) disable iff (!rstn)
    (flag_clear_wr && flag_clear_reg[FCLR_SB0_BIT] && !done) |=> !capture_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_set;
    @(posedge clk) disable iff (!rstn)
    done |=> capture_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion did not set flag");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
    ##1 capture_irq == (capture_flag && $past(irq_enable_reg[IER_SB0_BIT]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow flag and enable");

  property p_start;
    @(posedge clk) disable iff (!rstn)
    (state_r == ST_IDLE && go) |=> busy && time_measure_counter == 32'h0000_0000;
  endproperty
  a_start: assert property (p_start) else $error("start not honoured");

  property p_psc_div10;
    @(posedge clk) disable iff (!rstn)
    (bus0_tick && unit_enable_reg[UEN_PRESCALER_BIT] && prescaler_ratio_reg == 16'h0009)
      ##1 s_psc_quiet ##1 (unit_enable_reg[UEN_PRESCALER_BIT] && prescaler_ratio_reg == 16'h0009)
      |=> bus0_tick;
  endproperty
  a_psc_div10: assert property (p_psc_div10) else $error("prescaler ratio wrong");
endmodule

// ---- logic/edge_timer_pkg.sv ----
// Purpose: shared constants and types for the edge interval / edge count timer,
//          plus the clock-bus prescaler leaf module.
// Assumes: one 20 MHz clock, asynchronous active-low reset.
// Notes:   control fields travel as one packed struct.

// ------------------------------------------------------------
// package
// ------------------------------------------------------------
package edge_timer_pkg;
  localparam int CLK_HZ = 20_000_000;

  // unit enable bits
  localparam int UEN_PRESCALER_BIT = 0;
  localparam int UEN_TIMER_BIT     = 6;
  // start, interrupt enable and flag clear bits for sub-block 0
  localparam int START_SB0_BIT = 0;
  localparam int IER_SB0_BIT   = 0;
  localparam int FCLR_SB0_BIT  = 0;

  // measurement modes
  localparam logic [1:0] MODE_EDGE_WINDOW   = 2'h0;
  localparam logic [1:0] MODE_EDGE_INTERVAL = 2'h1;
  // effective edge polarity
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // only clock bus 0 exists in this sub-block
  localparam logic [3:0] CLK_BUS0 = 4'h0;

  // reset values and capture padding
  localparam logic [15:0] PSC_CNT_RST  = 16'h0000;
  localparam logic [31:0] TIME_CNT_RST = 32'h0000_0000;
  localparam logic [15:0] EDGE_CNT_RST = 16'h0000;
  localparam logic [31:0] CAPTURE_RST  = 32'h0000_0000;
  localparam logic [15:0] CAP_PAD      = 16'h0000;

  // control register layout: 0x05 = bus0/interval/rise, 0x01 = bus0/window/rise
  typedef struct packed {
    logic [3:0] bus_sel;
    logic [1:0] mode;
    logic [1:0] edge_sel;
  } subblock_ctrl_s;

  typedef enum logic {ST_IDLE, ST_RUN} meas_state_e;
endpackage

// ------------------------------------------------------------
// prescaler: one tick every (ratio + 1) clocks
// ------------------------------------------------------------
`timescale 1ns/1ns
module clock_bus_prescaler
  import edge_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        enable,
  input  wire logic [15:0] ratio_m1,
  output logic             tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  always_comb
  begin
    tick_nxt = enable && (cnt_r == ratio_m1);
    if (!enable || cnt_r == ratio_m1)
      cnt_nxt = PSC_CNT_RST;
    else
      cnt_nxt = cnt_r + 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= PSC_CNT_RST;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

// ---- bench/pulse_source.sv ----
// Purpose: far-side pulse generator feeding the measured input pin.
// Assumes: changes only on the falling clock edge.
// Notes:   pin rests low while stopped, so no stale level is seen.
`timescale 1ns/1ns
module pulse_source
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            pin
);
  logic [7:0] cnt;
  // ------------------------------------------------------------
  // square wave, first rise half clocks after run
  // ------------------------------------------------------------
  always @(negedge clk)
  begin
    if (!run)
    begin
      pin <= 1'b0;
      cnt <= 8'h00;
    end
    else if (cnt == half - 8'h01)
    begin
      pin <= ~pin;
      cnt <= 8'h00;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// ---- bench/edge_interval_count_timer_tb_top.sv ----
// Purpose: scenario bench for the edge interval / edge count timer.
// Assumes: 20 MHz clock, inputs moved on the falling edge.
// Notes:   timing results allow two ticks of slack for pin phase.
`timescale 1ns/1ns
module edge_interval_count_timer_tb_top;
  import edge_timer_pkg::*;
  logic           clk, rstn, fc_wr, pre_wr, run, pin, flag, irq, busy;
  logic [7:0]     uen, ier, fc, half;
  logic [15:0]    psc, en_num, pre_d, ecnt;
  logic [31:0]    start, gr_time, cap, tcnt;
  subblock_ctrl_s ctrl;
  int             err_total, total_checks;

  pulse_source src_u (.clk(clk), .run(run), .half(half), .pin(pin));
  edge_interval_count_timer dut_u (
    .clk(clk), .rstn(rstn), .unit_enable_reg(uen), .prescaler_ratio_reg(psc),
    .subblock_control(ctrl), .subblock_start_reg(start), .time_general_reg(gr_time),
    .edge_number_reg(en_num), .irq_enable_reg(ier), .flag_clear_wr(fc_wr),
    .flag_clear_reg(fc), .edge_preset_wr(pre_wr), .edge_preset_data(pre_d),
    .measure_input_pin(pin), .capture_data_reg(cap), .capture_flag(flag),
    .capture_irq(irq), .time_measure_counter(tcnt), .edge_counter(ecnt), .busy(busy));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // preset edge counter to zero, then go; software ordering
  task automatic arm(input logic [7:0] c, input logic [7:0] u, input logic [7:0] h);
    ctrl   = subblock_ctrl_s'(c);
    pre_d  = 16'h0000;
    pre_wr = 1'b1;
    cyc(1);
    pre_wr = 1'b0;
    half   = h;
    start  = 32'h0000_0001;
    uen    = u;
    // nba so the pulse model starts on the next falling edge, not by race
    run    <= 1'b1;
  endtask

  // stop in the same cycle as the clear so no fresh completion races the clear
  task automatic stop_clear();
    start = 32'h0000_0000;
    uen   = 8'h00;
    run   <= 1'b0;
    fc    = 8'h01;
    fc_wr = 1'b1;
    cyc(1);
    fc_wr = 1'b0;
    cyc(1);
    chk(flag, 0, 0);
    chk(irq, 0, 0);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 5000)
    begin
      cyc(1);
      n++;
    end
    chk(flag, 1, 1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_interval();
    psc    = 16'h0009;
    en_num = 16'h0005;
    ier    = 8'h01;
    arm(8'h05, 8'h41, 8'h32);
    cyc(2);
    chk(busy, 1, 1);
    cyc(100);
    chk(tcnt, 10, 10);
    wait_flag();
    chk(cap, 43, 47);
    chk(irq, 1, 1);
    ier = 8'h00;
    cyc(1);
    chk(irq, 0, 0);
    chk(flag, 1, 1);
    stop_clear();
  endtask

  task automatic t_window();
    ier     = 8'h00;
    gr_time = 32'h0000_0050;
    arm(8'h01, 8'h41, 8'd20);
    wait_flag();
    chk(cap, 19, 21);
    chk(irq, 0, 0);
    stop_clear();
  endtask

  task automatic t_gating();
    arm(8'h01, 8'h40, 8'd20);
    cyc(205);
    chk(ecnt, 5, 5);
    chk(tcnt, 0, 0);
    chk(flag, 0, 0);
    stop_clear();
    arm(8'h15, 8'h41, 8'h14);
    chk(ecnt, 0, 0);
    cyc(100);
    chk(tcnt, 0, 0);
    stop_clear();
  endtask

  // both edges, then falling edges only, with the time base held off
  task automatic t_polarity();
    arm(8'h03, 8'h40, 8'h14);
    cyc(205);
    chk(ecnt, 10, 10);
    stop_clear();
    arm(8'h02, 8'h40, 8'h14);
    cyc(205);
    chk(ecnt, 5, 5);
    stop_clear();
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #(50 * 20000);
    err_total++;
    wrap_up();
  end

  initial
  begin
    rstn = 1'b0;
    fc_wr = 1'b0;
    pre_wr = 1'b0;
    run = 1'b0;
    uen = 8'h00;
    ier = 8'h00;
    fc = 8'h00;
    half = 8'h14;
    psc = 16'h0009;
    en_num = 16'h0005;
    pre_d = 16'h0000;
    start = 32'h0000_0000;
    gr_time = 32'h0000_0050;
    ctrl = subblock_ctrl_s'(8'h00);
    err_total = 0;
    total_checks = 0;
    cyc(4);
    rstn = 1'b1;
    cyc(1);
    t_interval();
    t_window();
    t_gating();
    t_polarity();
    wrap_up();
  end
endmodule
